// ---- i2cmc_core.sv ----
`timescale 1ns/1ns
module i2cmc_core #(
  parameter int unsigned HALF_CYC = i2cmc_pkg::SCL_HALF_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic scl_pin_in,
  output logic scl_pin_out,
  output logic scl_pin_oe,
  input wire logic sda_pin_in,
  output logic sda_pin_out,
  output logic sda_pin_oe,
  output logic i2c_interrupt
);
  import i2cmc_pkg::*;

  if (HALF_CYC < 2 || HALF_CYC > 65535) begin : g_chk
    $error("HALF_CYC out of range");
  end

  typedef struct packed {
    logic [7:0] ctl;
    logic [7:0] sva;
    logic [7:0] shreg;
    logic [31:0] rdata;
    i2cmc_sel_t asel;
    logic awr;
    logic dfc;
    logic wakeup_select;
    logic start_request_fail_flag;
    logic busy;
    logic msts;
    logic coi;
    logic exc;
    logic trc;
    logic ackd;
    logic std;
    logic spd;
    logic waiting;
    logic standby;
    logic first;
    logic [3:0] cnt;
    logic scl_oe;
    logic sda_oe;
    i2cmc_mst_t mst;
    logic [15:0] div;
    logic irq;
  } i2cmc_core_t;

  i2cmc_core_t r;
  i2cmc_core_t n;
  i2cmc_sel_t sel;
  logic ap;
  logic tick;
  logic do_ctl;
  logic rel_wait;
  logic data_wr;
  logic en;
  logic [7:0] wval;
  logic [3:0] c;
  logic [3:0] bidx;
  logic coi_n;
  logic exc_n;
  logic trc_n;
  logic sb_n;
  logic ev_sta;
  logic ev_sto;
  logic ev_rise;
  logic ev_fall;

  i2cmc_line_if ln ();

  i2cmc_line_sync u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .scl_pin_in(scl_pin_in),
    .sda_pin_in(sda_pin_in),
    .ln(ln)
  );

  assign ln.enable = r.ctl[B_EN];
  assign ln.filter_on = r.dfc;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode
  always_comb begin
    if (haddr[1:0] != 2'h0) begin
      sel = SEL_NONE;
    end else if (haddr[31:2] == IDX_CTL0) begin
      sel = SEL_CTL0;
    end else if (haddr[31:2] == IDX_SVA) begin
      sel = SEL_SVA;
    end else if (haddr[31:2] == IDX_DATA) begin
      sel = SEL_DATA;
    end else if (haddr[31:2] == IDX_STAT) begin
      sel = SEL_STAT;
    end else if (haddr[31:2] == IDX_FLAG) begin
      sel = SEL_FLAG;
    end else if (haddr[31:2] == IDX_CTL1) begin
      sel = SEL_CTL1;
    end else if (haddr[31:2] == IDX_BITOP) begin
      sel = SEL_BITOP;
    end else begin
      sel = SEL_NONE;
    end
  end

  assign ap = hsel && hready && htrans == HTRANS_NONSEQ && hsize == HSIZE_WORD;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    n = r;
    wval = r.ctl;
    do_ctl = 1'b0;
    rel_wait = 1'b0;
    data_wr = 1'b0;
    en = r.ctl[B_EN];
    c = 4'h0;
    coi_n = r.coi;
    exc_n = r.exc;
    trc_n = r.trc;
    sb_n = r.standby;
    n.irq = 1'b0;
    tick = (r.div == 16'h0000);
    ev_sta = en && ln.start_det;
    ev_sto = en && ln.stop_det;
    ev_rise = en && r.busy && ln.scl_rise;
    ev_fall = en && r.busy && ln.scl_fall;
    bidx = (r.cnt == 4'h9) ? 4'h0 : r.cnt;

    // Half-period enable for the generated clock
    if (r.mst == M_IDLE || tick) begin
      n.div = 16'(HALF_CYC - 1);
    end else begin
      n.div = r.div - 16'h0001;
    end

    // Bus address phase; read data registered for the data phase
    n.asel = ap ? sel : SEL_NONE;
    n.awr = hwrite;
    if (ap && !hwrite) begin
      if (sel == SEL_CTL0) begin
        n.rdata = {24'h0, r.ctl & ~CTL0_PULSE_MASK};
      end else if (sel == SEL_SVA) begin
        n.rdata = {24'h0, r.sva};
      end else if (sel == SEL_DATA) begin
        n.rdata = {24'h0, r.shreg};
      end else if (sel == SEL_STAT) begin
        n.rdata = {24'h0, r.msts, r.coi, r.exc, r.trc, r.ackd, r.std, r.spd, r.waiting};
      end else if (sel == SEL_FLAG) begin
        n.rdata = {24'h0, r.start_request_fail_flag, r.busy, 6'h00};
      end else if (sel == SEL_CTL1) begin
        n.rdata = {28'h0, r.wakeup_select, r.dfc, en && ln.scl, en && ln.sda};
      end else begin
        n.rdata = 32'h0000_0000;
      end
    end

    // Data phase writes
    if (r.awr) begin
      case (r.asel)
        SEL_CTL0: begin
          wval = hwdata[7:0];
          do_ctl = 1'b1;
        end
        SEL_BITOP: begin
          wval[hwdata[2:0]] = hwdata[BITOP_VAL];
          do_ctl = 1'b1;
        end
        SEL_SVA: n.sva = {hwdata[7:1], 1'b0};
        SEL_DATA: begin
          n.shreg = hwdata[7:0];
          data_wr = 1'b1;
          rel_wait = r.waiting;
        end
        SEL_CTL1: begin
          n.wakeup_select = hwdata[C1_WUP];
          n.dfc = hwdata[C1_DFC];
        end
        default: ;
      endcase
    end

    if (do_ctl) begin
      // Release bits are never stored, so they act once and read back zero
      n.ctl = wval & ~CTL0_PULSE_MASK;
      en = wval[B_EN];
      if (en && wval[B_LREL]) begin
        n.ctl[B_STT] = 1'b0;
        n.ctl[B_SPT] = 1'b0;
        n.msts = 1'b0;
        n.exc = 1'b0;
        n.coi = 1'b0;
        n.trc = 1'b0;
        n.ackd = 1'b0;
        n.std = 1'b0;
        n.scl_oe = 1'b0;
        n.sda_oe = 1'b0;
        n.waiting = 1'b0;
        n.standby = 1'b1;
        n.mst = M_IDLE;
      end else if (en && wval[B_WREL] && r.waiting) begin
        rel_wait = 1'b1;
      end
      if (en && wval[B_STT] && !wval[B_LREL]) begin
        if (r.msts && r.waiting) begin
          n.mst = M_RSTA;
          n.waiting = 1'b0;
          n.sda_oe = 1'b0;
          rel_wait = 1'b0;
        end else if (r.busy || r.mst != M_IDLE) begin
          n.start_request_fail_flag = 1'b1;
          n.ctl[B_STT] = 1'b0;
        end else begin
          n.start_request_fail_flag = 1'b0;
          n.mst = M_START;
        end
      end else if (en && wval[B_SPT] && !wval[B_LREL] && r.msts && r.waiting) begin
        n.mst = M_STOP;
        n.waiting = 1'b0;
        n.sda_oe = 1'b1;
        rel_wait = 1'b0;
      end
    end

    if (rel_wait) begin
      n.waiting = 1'b0;
      n.scl_oe = 1'b0;
      if (r.cnt == 4'h9 && r.trc) begin
        n.trc = 1'b0;
        n.sda_oe = 1'b0;
      end else if (data_wr && r.trc && r.cnt != 4'h8) begin
        n.sda_oe = ~hwdata[7];
      end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Line events come after software so a hardware set wins
    if (ev_sta) begin
      n.std = 1'b1;
      n.spd = 1'b0;
      n.busy = 1'b1;
      n.cnt = 4'hF; // Start's own clock fall wraps this to zero
      n.first = 1'b1;
      n.coi = 1'b0;
      n.exc = 1'b0;
      n.ackd = 1'b0;
      if (r.mst == M_IDLE) begin
        n.trc = 1'b0;
      end
    end

    if (ev_sto) begin
      n.spd = 1'b1;
      n.std = 1'b0;
      n.busy = 1'b0;
      n.msts = 1'b0;
      n.standby = 1'b0;
      n.waiting = 1'b0;
      n.cnt = 4'h0;
      n.scl_oe = 1'b0;
      n.sda_oe = 1'b0;
      n.mst = M_IDLE;
      n.ctl[B_SPT] = 1'b0;
      n.irq = r.ctl[B_SPIE] && !r.wakeup_select;
    end

    if (ev_rise) begin
      if (bidx < 4'h8) begin
        n.shreg = {r.shreg[6:0], ln.sda};
      end else if (r.trc) begin
        n.ackd = !ln.sda;
      end
    end

    if (ev_fall) begin
      c = (r.cnt == 4'h9) ? 4'h1 : r.cnt + 4'h1;
      n.cnt = c;
      if (c < 4'h8) begin
        n.sda_oe = r.trc && !r.shreg[7];
      end else if (c == 4'h8) begin
        if (r.first) begin
          coi_n = !r.msts && r.shreg[7:1] == r.sva[7:1];
          exc_n = !r.msts && r.shreg[7:4] == EXT_CODE_HI;
          trc_n = r.msts ? !r.shreg[0] : (coi_n && r.shreg[0]);
          sb_n = r.standby && !(coi_n || exc_n);
          n.coi = coi_n;
          n.exc = exc_n;
          n.trc = trc_n;
          n.standby = sb_n;
        end
        // Address match acks the address byte whatever ack enable says
        n.sda_oe = !r.trc && !sb_n && (r.ctl[B_ACKE] || (r.first && coi_n));
        if (!r.ctl[B_WTIM] && (!r.first || exc_n) && !sb_n) begin
          n.waiting = 1'b1;
          n.scl_oe = 1'b1;
          n.irq = 1'b1;
        end
      end else begin
        n.sda_oe = 1'b0;
        if ((r.ctl[B_WTIM] || r.first) && !r.standby && !(r.first && r.exc && !r.ctl[B_WTIM])) begin
          n.waiting = 1'b1;
          n.scl_oe = 1'b1;
          n.irq = 1'b1;
        end
        n.first = 1'b0;
      end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Master condition generator
    case (r.mst)
      M_START: begin
        if (tick) begin
          if (!r.sda_oe) begin
            n.sda_oe = 1'b1;
          end else begin
            n.scl_oe = 1'b1;
            n.msts = 1'b1;
            n.trc = 1'b1;
            n.waiting = 1'b1;
            n.ctl[B_STT] = 1'b0;
            n.mst = M_RUN;
          end
        end
      end
      M_RUN: begin
        // A released clock held low by a slave is not driven again yet
        if (tick && !r.waiting) begin
          if (r.scl_oe) begin
            n.scl_oe = 1'b0;
          end else if (ln.scl) begin
            n.scl_oe = 1'b1;
          end
        end
      end
      M_RSTA: begin
        if (tick) begin
          n.scl_oe = 1'b0;
          n.sda_oe = 1'b0;
          n.mst = M_START;
        end
      end
      M_STOP: begin
        if (tick) begin
          if (r.scl_oe) begin
            n.scl_oe = 1'b0;
          end else begin
            n.sda_oe = 1'b0;
            n.msts = 1'b0;
            n.ctl[B_SPT] = 1'b0;
            n.mst = M_IDLE;
          end
        end
      end
      default: ;
    endcase

    ////////////////////////////////////////////////////////////////////////////
    // Disabled: everything but the configuration, the data register, the bus address phase and read data and the clock divider is held cleared
    if (!n.ctl[B_EN]) begin
      n.msts = 1'b0;
      n.coi = 1'b0;
      n.exc = 1'b0;
      n.trc = 1'b0;
      n.ackd = 1'b0;
      n.std = 1'b0;
      n.spd = 1'b0;
      n.waiting = 1'b0;
      n.standby = 1'b0;
      n.first = 1'b0;
      n.cnt = 4'h0;
      n.scl_oe = 1'b0;
      n.sda_oe = 1'b0;
      n.mst = M_IDLE;
      n.start_request_fail_flag = 1'b0;
      n.busy = 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= '{ctl: CTL0_RESET, sva: SVA_RESET, asel: SEL_NONE, mst: M_IDLE,
             default: '0};
    end else begin
      r <= n;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = HRESP_OKAY;
  assign hrdata = r.rdata;
  // Open drain: only ever pulls low
  assign scl_pin_out = 1'b0;
  assign sda_pin_out = 1'b0;
  assign scl_pin_oe = r.scl_oe;
  assign sda_pin_oe = r.sda_oe;
  assign i2c_interrupt = r.irq;

endmodule

// ---- i2cmc_pkg.sv ----
package i2cmc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned SCL_HALF_NS = 5000;
  localparam int unsigned SCL_HALF_CYC = (SCL_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  ////////////////////////////////////////////////////////////////////////////
  // Register indices, byte address is four times the index
  localparam logic [29:0] IDX_CTL0 = 30'h0000FFA7;
  localparam logic [29:0] IDX_SVA = 30'h0000FFA6;
  localparam logic [29:0] IDX_DATA = 30'h0000FFA5;
  localparam logic [29:0] IDX_STAT = 30'h0000FFAA;
  localparam logic [29:0] IDX_FLAG = 30'h0000FFAB;
  localparam logic [29:0] IDX_CTL1 = 30'h0000FFAC;
  localparam logic [29:0] IDX_BITOP = 30'h0000FFAD;

  localparam logic [7:0] CTL0_RESET = 8'h00;
  localparam logic [7:0] SVA_RESET = 8'h00;

  // Main control fields
  localparam int B_EN = 7;
  localparam int B_LREL = 6;
  localparam int B_WREL = 5;
  localparam int B_SPIE = 4;
  localparam int B_WTIM = 3;
  localparam int B_ACKE = 2;
  localparam int B_STT = 1;
  localparam int B_SPT = 0;
  localparam logic [7:0] CTL0_PULSE_MASK = 8'h60;

  // Second control fields
  localparam int C1_WUP = 3;
  localparam int C1_DFC = 2;
  localparam int C1_CLD = 1;
  localparam int C1_DAD = 0;

  // Single-bit write: bit index in [2:0], value in [3]
  localparam int BITOP_VAL = 3;

  // Extension code: upper nibble of the first byte
  localparam logic [3:0] EXT_CODE_HI = 4'h0;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic HRESP_OKAY = 1'b0;

  typedef enum logic [2:0] {
    SEL_NONE = 3'h0,
    SEL_CTL0 = 3'h1,
    SEL_SVA = 3'h2,
    SEL_DATA = 3'h3,
    SEL_STAT = 3'h4,
    SEL_FLAG = 3'h5,
    SEL_CTL1 = 3'h6,
    SEL_BITOP = 3'h7
  } i2cmc_sel_t;

  typedef enum logic [2:0] {
    M_IDLE = 3'h0,
    M_START = 3'h1,
    M_RUN = 3'h2,
    M_RSTA = 3'h3,
    M_STOP = 3'h4
  } i2cmc_mst_t;

endpackage

// ---- i2cmc_line_if.sv ----
`timescale 1ns/1ns
interface i2cmc_line_if;
  logic enable;
  logic filter_on;
  logic scl;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  modport sync (input enable, input filter_on, output scl, output sda,
                output scl_rise, output scl_fall, output start_det, output stop_det);
  modport core (output enable, output filter_on, input scl, input sda,
                input scl_rise, input scl_fall, input start_det, input stop_det);
endinterface

// ---- i2cmc_line_sync.sv ----
`timescale 1ns/1ns
module i2cmc_line_sync (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic scl_pin_in,
  input wire logic sda_pin_in,
  i2cmc_line_if.sync ln
);
  import i2cmc_pkg::*;

  // Bit 1 is the clock line, bit 0 the data line
  typedef struct packed {
    logic [1:0] s1;
    logic [1:0] s2;
    logic [1:0] s3;
    logic [1:0] lvl;
    logic rise;
    logic fall;
    logic sta;
    logic sto;
  } i2cmc_sync_t;

  i2cmc_sync_t r;
  i2cmc_sync_t n;
  logic [1:0] nl;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    n = r;
    nl = r.lvl;
    n.s1 = {scl_pin_in, sda_pin_in};
    n.s2 = r.s1;
    n.s3 = r.s2;
    // Filter takes a new level only after two agreeing samples
    if (!ln.filter_on || r.s2 == r.s3) begin
      nl = r.s2;
    end
    n.rise = 1'b0;
    n.fall = 1'b0;
    n.sta = 1'b0;
    n.sto = 1'b0;
    if (!ln.enable) begin
      // With the filter on, idle lines are assumed while off, so a low data line shows up as a start
      n.lvl = ln.filter_on ? 2'b11 : r.s2;
    end else begin
      n.lvl = nl;
      n.rise = !r.lvl[1] && nl[1];
      n.fall = r.lvl[1] && !nl[1];
      n.sta = r.lvl[1] && nl[1] && r.lvl[0] && !nl[0];
      n.sto = r.lvl[1] && nl[1] && !r.lvl[0] && nl[0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= '{s1: 2'b11, s2: 2'b11, s3: 2'b11, lvl: 2'b11, default: 1'b0};
    end else begin
      r <= n;
    end
  end

  assign ln.scl = r.lvl[1];
  assign ln.sda = r.lvl[0];
  assign ln.scl_rise = r.rise;
  assign ln.scl_fall = r.fall;
  assign ln.start_det = r.sta;
  assign ln.stop_det = r.sto;

endmodule

// ---- i2cmc_core_chk.sv ----
`timescale 1ns/1ns
module i2cmc_core_chk (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic hresp,
  input wire logic scl_pin_out,
  input wire logic scl_pin_oe,
  input wire logic sda_pin_out,
  input wire logic sda_pin_oe,
  input wire logic i2c_interrupt
);
  import i2cmc_pkg::*;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  ////////////////////////////////////////////////////////////////////////////
  // Shadow of op_enable from byte and single-bit writes
  logic take;
  logic wr_ctl_r;
  logic wr_bit_r;
  logic en_r;
  assign take = hsel && hready && htrans == HTRANS_NONSEQ && hsize == HSIZE_WORD;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ctl_r <= 1'b0;
      wr_bit_r <= 1'b0;
      en_r <= 1'b0;
    end else begin
      wr_ctl_r <= take && hwrite && haddr == {IDX_CTL0, 2'b00};
      wr_bit_r <= take && hwrite && haddr == {IDX_BITOP, 2'b00};
      if (wr_ctl_r) begin
        en_r <= hwdata[B_EN];
      end else if (wr_bit_r && hwdata[2:0] == 3'h7) begin
        en_r <= hwdata[BITOP_VAL];
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  AST_HREADY: assert property (hreadyout == 1'b1) else $error("hreadyout low");
  AST_HRESP: assert property (hresp == HRESP_OKAY) else $error("hresp not okay");
  AST_RST_QUIET: assert property ($rose(hresetn) |-> !scl_pin_oe && !sda_pin_oe)
    else $error("lines pulled after reset");
  AST_RD_ZERO: assert property (take && !hwrite && haddr == {IDX_CTL0, 2'b00}
    |=> !hrdata[B_LREL] && !hrdata[B_WREL] && hrdata[31:8] == 24'h0)
    else $error("release bits read nonzero");
  AST_RD_UNMAPPED: assert property (take && !hwrite && haddr[31:18] != 14'h0
    |=> hrdata == 32'h0) else $error("unmapped read nonzero");
  AST_OD_LOW: assert property (!scl_pin_out && !sda_pin_out)
    else $error("open-drain output driven high");
  AST_IRQ_PULSE: assert property (i2c_interrupt |=> !i2c_interrupt)
    else $error("interrupt longer than one cycle");
  AST_DISABLED: assert property (!en_r && $past(en_r) == 1'b0 && $past(en_r, 2) == 1'b0
    |-> !scl_pin_oe && !sda_pin_oe && !i2c_interrupt) else $error("activity while disabled");
  AST_LREL_FREE: assert property (wr_ctl_r && hwdata[7:6] == 2'b11
    |-> ##[1:4] (!scl_pin_oe && !sda_pin_oe)) else $error("lines held after release");
  COV_IRQ: cover property (i2c_interrupt);
  COV_LREL: cover property (wr_ctl_r && hwdata[7:6] == 2'b11);
  COV_MASTER: cover property ($rose(scl_pin_oe));
endmodule

// ---- i2cmc_bus_peer.sv ----
`timescale 1ns/1ns
module i2cmc_bus_peer (
  input wire logic dut_scl_oe,
  input wire logic dut_sda_oe,
  output logic scl,
  output logic sda
);
  localparam int HALF_NS = 80;
  logic scl_oe_r = 1'b0;
  logic sda_oe_r = 1'b0;
  // Pull-ups: a line is low while any party pulls it, clock stands high between frames
  assign scl = !(dut_scl_oe || scl_oe_r);
  assign sda = !(dut_sda_oe || sda_oe_r);
  task pull_sda(input logic v);
    sda_oe_r = v;
  endtask
  task gen_start();
    sda_oe_r = 1'b1;
    #(HALF_NS);
    scl_oe_r = 1'b1;
    #(HALF_NS);
  endtask
  task bits(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      sda_oe_r = !b[i];
      #(HALF_NS);
      scl_oe_r = 1'b0;
      #(HALF_NS);
      scl_oe_r = 1'b1;
    end
  endtask
  // Ninth clock with the data line free; a stretched clock is waited out
  task ninth(output logic ack);
    sda_oe_r = 1'b0;
    #(HALF_NS);
    scl_oe_r = 1'b0;
    wait (scl === 1'b1);
    #(HALF_NS / 2);
    ack = !sda;
    #(HALF_NS / 2);
    scl_oe_r = 1'b1;
    #(HALF_NS);
  endtask
  task gen_stop();
    sda_oe_r = 1'b1;
    #(HALF_NS);
    scl_oe_r = 1'b0;
    #(HALF_NS);
    sda_oe_r = 1'b0;
    #(HALF_NS);
  endtask
endmodule

// ---- i2cmc_core_tb.sv ----
`timescale 1ns/1ns
module i2cmc_core_tb;
  import i2cmc_pkg::*;
  typedef struct packed {
    logic [29:0] widx;
    logic [7:0] wdat;
    logic [29:0] ridx;
    logic [7:0] exp;
  } i2cmc_row_t;
  localparam logic [29:0] IDX_UNMAP = 30'h00010000;
  localparam i2cmc_row_t ROWS [11] = '{
    '{IDX_UNMAP, 8'h00, IDX_CTL0, 8'h00},
    '{IDX_CTL0, 8'h1C, IDX_CTL0, 8'h1C},
    '{IDX_CTL0, 8'h7C, IDX_CTL0, 8'h1C},
    '{IDX_CTL1, 8'h0F, IDX_CTL1, 8'h0C},
    '{IDX_CTL0, 8'h9C, IDX_CTL0, 8'h9C},
    '{IDX_CTL0, 8'hFC, IDX_CTL0, 8'h9C},
    '{IDX_CTL0, 8'h00, IDX_STAT, 8'h00},
    '{IDX_BITOP, 8'h0F, IDX_CTL0, 8'h80},
    '{IDX_BITOP, 8'h0C, IDX_CTL0, 8'h90},
    '{IDX_BITOP, 8'h07, IDX_CTL0, 8'h10},
    '{IDX_CTL1, 8'h00, IDX_UNMAP, 8'h00}};
  logic hclk;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout;
  logic [31:0] hrdata;
  logic hresp;
  logic scl_pin_oe;
  logic sda_pin_oe;
  logic i2c_interrupt;
  logic scl;
  logic sda;
  int err_count = 0;
  int cmp_count = 0;
  int irq_cnt = 0;
  int cyc = 0;
  i2cmc_core #(.HALF_CYC(4)) i2cmc_core_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp, .scl_pin_in(scl),
    .scl_pin_out(), .scl_pin_oe, .sda_pin_in(sda), .sda_pin_out(), .sda_pin_oe, .i2c_interrupt);
  i2cmc_bus_peer i2cmc_bus_peer_i (.dut_scl_oe(scl_pin_oe), .dut_sda_oe(sda_pin_oe), .scl, .sda);
  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    if (i2c_interrupt === 1'b1) begin
      irq_cnt <= irq_cnt + 1;
    end
  end
  // Ceiling well above the under a thousand cycles the sequence needs
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      test_done();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task test_done();
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One single transfer; the wait on hreadyout is bounded by the timeout
  task bus(input logic w, input logic [29:0] idx, input logic [7:0] d, output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {idx, 2'b00};
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    hsize <= HSIZE_WORD;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task wr(input logic [29:0] idx, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, idx, d, q);
  endtask
  task rdc(input string nm, input logic [29:0] idx, input logic [7:0] m, input logic [7:0] e);
    logic [31:0] q;
    bus(1'b0, idx, 8'h00, q);
    chk(nm, {24'h0, e}, q & {24'hFFFFFF, m});
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] q;
    logic ack;
    int n;
    repeat (10) @(posedge hclk);
    chk("oe at reset", 32'h0, {30'h0, scl_pin_oe, sda_pin_oe});
    hresetn <= 1'b1;
    for (int i = 0; i < 11; i++) begin
      wr(ROWS[i].widx, ROWS[i].wdat);
      rdc("row", ROWS[i].ridx, 8'hFF, ROWS[i].exp);
    end
    // Stop interrupt, release clears start detection, wakeup select masks the stop interrupt
    wr(IDX_CTL0, 8'h90);
    i2cmc_bus_peer_i.gen_start();
    rdc("busy", IDX_FLAG, 8'h40, 8'h40);
    rdc("start seen", IDX_STAT, 8'h04, 8'h04);
    wr(IDX_CTL0, 8'hD0);
    rdc("status after release", IDX_STAT, 8'hFF, 8'h00);
    rdc("ctl after release", IDX_CTL0, 8'hFF, 8'h90);
    i2cmc_bus_peer_i.gen_stop();
    repeat (10) @(posedge hclk);
    chk("stop irq", 32'd1, 32'(irq_cnt));
    wr(IDX_CTL1, 8'h08);
    i2cmc_bus_peer_i.gen_start();
    i2cmc_bus_peer_i.gen_stop();
    repeat (10) @(posedge hclk);
    chk("wakeup irq", 32'd1, 32'(irq_cnt));
    // Disabling in mid-frame resets flags, status and line levels
    i2cmc_bus_peer_i.gen_start();
    wr(IDX_CTL0, 8'h00);
    rdc("flag off", IDX_FLAG, 8'hC0, 8'h00);
    rdc("status off", IDX_STAT, 8'hFF, 8'h00);
    rdc("levels off", IDX_CTL1, 8'hFF, 8'h08);
    i2cmc_bus_peer_i.gen_stop();
    // Enabling with data low and filter on sees a start at once
    wr(IDX_CTL1, 8'h04);
    i2cmc_bus_peer_i.pull_sda(1'b1);
    wr(IDX_CTL0, 8'h80);
    repeat (4) @(posedge hclk);
    rdc("spurious start", IDX_STAT, 8'h04, 8'h04);
    wr(IDX_BITOP, 8'h0E);
    rdc("status cleared", IDX_STAT, 8'hFF, 8'h00);
    i2cmc_bus_peer_i.pull_sda(1'b0);
    wr(IDX_CTL0, 8'h00);
    wr(IDX_CTL1, 8'h00);
    // Master start, then abandon it
    wr(IDX_CTL0, 8'h82);
    n = 0;
    while (scl_pin_oe !== 1'b1 && n < 100) begin
      @(posedge hclk);
      n++;
    end
    chk("start drive", 32'h3, {30'h0, scl_pin_oe, sda_pin_oe});
    rdc("master wait", IDX_STAT, 8'h81, 8'h81);
    wr(IDX_CTL0, 8'hC0);
    repeat (4) @(posedge hclk);
    chk("freed", 32'h0, {30'h0, scl_pin_oe, sda_pin_oe});
    rdc("trigger cleared", IDX_CTL0, 8'hFF, 8'h80);
    rdc("master cleared", IDX_STAT, 8'hFF, 8'h00);
    // Slave receive: address waits at ninth fall, data byte at eighth fall
    wr(IDX_SVA, 8'hA4);
    i2cmc_bus_peer_i.gen_start();
    i2cmc_bus_peer_i.bits(8'hA4);
    i2cmc_bus_peer_i.ninth(ack);
    chk("address ack", 32'h1, {31'h0, ack});
    chk("address wait irq", 32'd2, 32'(irq_cnt));
    chk("ninth hold", 32'h1, {31'h0, scl_pin_oe});
    rdc("address match", IDX_STAT, 8'h41, 8'h41);
    wr(IDX_CTL0, 8'hA4);
    rdc("wait bit reads zero", IDX_CTL0, 8'hFF, 8'h84);
    chk("wait freed", 32'h0, {31'h0, scl_pin_oe});
    i2cmc_bus_peer_i.bits(8'h3C);
    repeat (10) @(posedge hclk);
    chk("eighth wait irq", 32'd3, 32'(irq_cnt));
    chk("eighth hold and ack", 32'h3, {30'h0, scl_pin_oe, sda_pin_oe});
    rdc("data byte", IDX_DATA, 8'hFF, 8'h3C);
    wr(IDX_BITOP, 8'h0D);
    i2cmc_bus_peer_i.ninth(ack);
    chk("data ack", 32'h1, {31'h0, ack});
    i2cmc_bus_peer_i.gen_stop();
    repeat (10) @(posedge hclk);
    rdc("stop seen", IDX_STAT, 8'h02, 8'h02);
    rdc("bus free", IDX_FLAG, 8'h40, 8'h00);
    chk("no stop irq", 32'd3, 32'(irq_cnt));
    test_done();
  end
endmodule
bind i2cmc_core i2cmc_core_chk i2cmc_core_chk_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
  .hsize, .hwdata, .hready, .hreadyout, .hrdata, .hresp, .scl_pin_out, .scl_pin_oe,
  .sda_pin_out, .sda_pin_oe, .i2c_interrupt);
